// File: hdl/hsp_serial_port.sv
// Serial port selection, buffers, SPI slave and UART flow control
`timescale 1ns/1ps
`include "hsp_regs.svh"
module hsp_serial_port
   import hsp_pkg::*;
(
   input  wire logic       ref_clk,        // Module clock, 125 MHz
   input  wire logic       rst,            // Reset, high; synchronous to ref_clk, asynchronous for SPI link
   input  wire logic       th_variant,     // High on through-hole part
   input  wire logic       dout_pin_in,    // Level on serial output pin
   input  wire logic       uart_en_cfg,    // Stored config UART enable
   input  wire logic       spi_en_cfg,     // Stored config SPI enable
   input  wire hsp_cfg_s   stored_cfg,     // Stored pin settings
   input  wire logic       flash_wr_cmd,   // Write-to-flash command pulse
   output hsp_cfg_s        active_cfg,     // Pin settings in force
   output logic            flash_store,    // Store active_cfg pulse
   input  wire logic       cts_function_setting, // CTS enable
   input  wire logic       rts_function_setting, // RTS enable
   input  wire logic [11:0] flow_threshold_setting, // New threshold
   input  wire logic       ft_wr,          // Load threshold pulse
   output logic [11:0]     ft_value,       // Threshold in force
   input  wire logic       rts_n_in,       // Host RTS pin, low = go
   output logic            cts_n_out,      // CTS pin, high = stop
   input  wire hsp_byte_s  uart_rx,        // Byte from UART receiver
   output hsp_byte_s       uart_tx,        // Byte to UART transmitter
   input  wire logic       uart_tx_ready,  // UART transmitter ready
   output hsp_byte_s       rx_out,         // Received byte to system
   input  wire logic       rx_out_ready,   // System takes rx_out
   output logic            rx_drop,        // Receive byte discarded
   input  wire hsp_byte_s  sys_tx,         // RF data byte from system
   input  wire logic       sys_tx_first,   // First byte of packet
   input  wire logic [11:0] sys_tx_len,    // Packet length on first
   output logic            sys_tx_ready,   // Block takes sys_tx
   output logic            tx_drop,        // Packet dropped pulse
   output logic [3:0]      port_sel,       // Selection state
   input  wire logic       spi_sck,        // SPI clock
   input  wire logic       spi_ssel_n,     // SPI slave select, low
   input  wire logic       spi_mosi,       // SPI data in
   output logic            spi_miso_o,     // SPI data out
   output logic            spi_miso_oe,    // SPI data out enable
   output logic            attention_out   // Data queued for master
);

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   function automatic logic [11:0] wrap(input logic [11:0] i,
                                        input logic [11:0] d);
      wrap = (i == d - 12'h001) ? 12'h000 : i + 12'h001;
   endfunction : wrap

   function automatic logic [7:0] stat_byte(input logic [2:0] i);
      unique case (i)
         3'h0:    stat_byte = 8'h7e;
         3'h1:    stat_byte = 8'h00;
         3'h2:    stat_byte = 8'h02;
         3'h3:    stat_byte = 8'h8a;
         3'h4:    stat_byte = 8'h00;
         default: stat_byte = 8'h75;
      endcase
   endfunction : stat_byte

   //------------------------------------------------------------
   // SPI clock domain
   //------------------------------------------------------------
   typedef struct packed {
      logic [6:0] rsh;
      logic [7:0] rbyte;
      logic       rtog;
      logic [7:0] tsh;
      logic       req_s1;
      logic       req_s2;
      logic       ack;
   } hsp_lnk_s;

   // The request toggle moves only on sck edges, so a handed-over byte
   // waits two edges and the first byte of a frame is the one loaded
   // at the end of the previous frame; hosts treat it as fill
   hsp_lnk_s   l_r, l_nxt;
   logic [2:0] bit_r;
   logic       tx_req_r;
   logic [7:0] tx_byte_r;

   // Bit counter restarts with every select so a frame is byte aligned
   always_ff @(posedge spi_sck or posedge spi_ssel_n) begin
      if (spi_ssel_n) begin
         bit_r <= 3'h0;
      end else begin
         bit_r <= bit_r + 3'h1;
      end
   end

   always_comb begin
      l_nxt        = l_r;
      l_nxt.req_s1 = tx_req_r;
      l_nxt.req_s2 = l_r.req_s1;
      l_nxt.rsh    = {l_r.rsh[5:0], spi_mosi};
      if (bit_r == `HSP_LAST_BIT) begin
         l_nxt.rbyte = {l_r.rsh, spi_mosi};
         l_nxt.rtog  = ~l_r.rtog;
         if (l_r.req_s2 != l_r.ack) begin
            l_nxt.tsh = tx_byte_r;
            l_nxt.ack = l_r.req_s2;
         end else begin
            l_nxt.tsh = {8{l_r.tsh[0]}};
         end
      end
   end

   // Async reset loads constants only; sck may stand still in reset
   always_ff @(posedge spi_sck or posedge rst) begin
      if (rst) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   // Mode 0: bit leaves after each rising edge, sampled on the next
   assign spi_miso_o  = l_r.tsh[~bit_r];
   assign spi_miso_oe = ~spi_ssel_n;

   //------------------------------------------------------------
   // Module clock domain
   //------------------------------------------------------------
   typedef struct packed {
      hsp_sel_e    sel;
      logic [7:0]  boot_cnt;
      logic        forced;
      hsp_cfg_s    fcfg;
      logic [1:0]  dout_s;
      logic [1:0]  ssel_s;
      logic [1:0]  rts_s;
      logic [2:0]  rtog_s;
      logic [1:0]  ack_s;
      logic        req;
      logic [7:0]  tbyte;
      logic        stat_go;
      logic [2:0]  stat_idx;
      logic [11:0] ft;
      logic        stop;
      logic [11:0] rx_wr;
      logic [11:0] rx_rd;
      logic [11:0] rx_cnt;
      logic [11:0] tx_wr;
      logic [11:0] tx_rd;
      logic [11:0] tx_cnt;
      logic        tx_drop_pkt;
      logic        flash_store;
      logic        rx_drop;
      logic        tx_drop;
      hsp_byte_s   utx;
   } hsp_st_s;

   hsp_st_s    s_r, s_nxt;
   logic [7:0] rx_mem [`HSP_RX_DEPTH];
   logic [7:0] tx_mem [`HSP_TX_DEPTH];
   logic       rx_we, tx_we;
   logic [7:0] rx_wd, tx_wd;
   logic       spi_byte_ev, uart_ok;
   logic [7:0] tx_rd_idx, tx_wr_idx;

   // Transmit store is 256 deep: low pointer bits index it
   assign tx_rd_idx = s_r.tx_rd[7:0];
   assign tx_wr_idx = s_r.tx_wr[7:0];

   assign spi_byte_ev = s_r.rtog_s[2] ^ s_r.rtog_s[1];
   // Gates only new loads; a byte already handed over finishes,
   // well inside the four character allowance
   assign uart_ok     = ~rts_function_setting | ~s_r.rts_s[1];

   always_comb begin
      s_nxt             = s_r;
      s_nxt.dout_s      = {s_r.dout_s[0], dout_pin_in};
      s_nxt.ssel_s      = {s_r.ssel_s[0], spi_ssel_n};
      s_nxt.rts_s       = {s_r.rts_s[0], rts_n_in};
      s_nxt.rtog_s      = {s_r.rtog_s[1:0], l_r.rtog};
      s_nxt.ack_s       = {s_r.ack_s[0], l_r.ack};
      s_nxt.flash_store = 1'b0;
      s_nxt.rx_drop     = 1'b0;
      s_nxt.tx_drop     = 1'b0;
      rx_we = 1'b0;
      rx_wd = 8'h00;
      tx_we = 1'b0;
      tx_wd = 8'h00;

      //------------------------------
      // Port selection
      //------------------------------
      unique case (s_r.sel)
         HSP_BOOT: begin
            s_nxt.boot_cnt = s_r.boot_cnt + 8'h01;
            // Straps read once, after the synchronisers settle
            if (s_r.boot_cnt == `HSP_STRAP_CYC) begin
               if (th_variant && !s_r.dout_s[1]) begin
                  s_nxt.sel     = HSP_SPI;
                  s_nxt.forced  = 1'b1;
                  s_nxt.stat_go = 1'b1;
                  s_nxt.fcfg    = stored_cfg;
                  if (stored_cfg.pin1 == `HSP_FN_ZERO) begin
                     s_nxt.fcfg.pin1 = `HSP_FN_SPI;
                  end
                  s_nxt.fcfg.pin2  = `HSP_FN_SPI;
                  s_nxt.fcfg.pin3  = `HSP_FN_SPI;
                  s_nxt.fcfg.pin4  = `HSP_FN_SPI;
                  s_nxt.fcfg.dio12 = `HSP_FN_SPI;
               end else if (!uart_en_cfg && spi_en_cfg) begin
                  s_nxt.sel = HSP_SPI;
               end else if (uart_en_cfg && spi_en_cfg) begin
                  s_nxt.sel = HSP_UNDEC;
               end else begin
                  s_nxt.sel = HSP_UART;
               end
            end
         end
         HSP_UNDEC: begin
            if (uart_rx.valid) begin
               s_nxt.sel = HSP_UART;
            end else if (spi_byte_ev || !s_r.ssel_s[1]) begin
               s_nxt.sel = HSP_SPI;
            end
         end
         HSP_UART: s_nxt.sel = HSP_UART;
         HSP_SPI:  s_nxt.sel = HSP_SPI;
      endcase

      //------------------------------
      // Flash write
      //------------------------------
      // Only a write in SPI keeps forced settings past reset
      if (flash_wr_cmd && s_r.sel == HSP_SPI) begin
         s_nxt.flash_store = 1'b1;
      end

      //------------------------------
      // Threshold
      //------------------------------
      // Clamped at load so 17 bytes of headroom always remain
      if (ft_wr) begin
         s_nxt.ft = (flow_threshold_setting > `HSP_FT_MAX) ?
                    `HSP_FT_MAX : flow_threshold_setting;
      end

      //------------------------------
      // Receive side
      //------------------------------
      // UART writes outside boot and SPI mode, SPI outside UART mode; a pop in the same cycle
      // does not make room, so the newest byte is lost first
      if (uart_rx.valid && s_r.sel != HSP_SPI && s_r.sel != HSP_BOOT) begin
         rx_we = 1'b1;
         rx_wd = uart_rx.data;
      end else if (spi_byte_ev && s_r.sel != HSP_UART) begin
         rx_we = 1'b1;
         rx_wd = l_r.rbyte;
      end
      if (rx_out_ready && s_r.rx_cnt != 12'h000) begin
         s_nxt.rx_rd  = wrap(s_r.rx_rd, `HSP_RX_DEPTH);
         s_nxt.rx_cnt = s_nxt.rx_cnt - 12'h001;
      end
      if (rx_we) begin
         if (s_r.rx_cnt == `HSP_RX_DEPTH) begin
            rx_we         = 1'b0;
            s_nxt.rx_drop = 1'b1;
         end else begin
            s_nxt.rx_wr  = wrap(s_r.rx_wr, `HSP_RX_DEPTH);
            s_nxt.rx_cnt = s_nxt.rx_cnt + 12'h001;
         end
      end

      //------------------------------
      // CTS with hysteresis
      //------------------------------
      // One cycle late at most, well inside the headroom
      if (s_r.rx_cnt >= s_r.ft) begin
         s_nxt.stop = 1'b1;
      end else if (s_r.rx_cnt <= s_r.ft - `HSP_FT_HYST) begin
         s_nxt.stop = 1'b0;
      end

      //------------------------------
      // Transmit drain
      //------------------------------
      if (s_r.utx.valid && uart_tx_ready) begin
         s_nxt.utx.valid = 1'b0;
      end
      if (s_r.tx_cnt != 12'h000) begin
         if (s_r.sel == HSP_SPI) begin
            if (s_r.req == s_r.ack_s[1]) begin
               s_nxt.tbyte  = tx_mem[tx_rd_idx];
               s_nxt.req    = ~s_r.req;
               s_nxt.tx_rd  = wrap(s_r.tx_rd, `HSP_TX_DEPTH);
               s_nxt.tx_cnt = s_nxt.tx_cnt - 12'h001;
            end
         end else if (s_r.sel != HSP_BOOT && !s_nxt.utx.valid && uart_ok) begin
            s_nxt.utx.valid = 1'b1;
            s_nxt.utx.data  = tx_mem[tx_rd_idx];
            s_nxt.tx_rd     = wrap(s_r.tx_rd, `HSP_TX_DEPTH);
            s_nxt.tx_cnt    = s_nxt.tx_cnt - 12'h001;
         end
      end

      //------------------------------
      // Transmit fill
      //------------------------------
      // Status frame first, then whole packets; the room check
      // ignores this cycle's drain, erring by one byte at most
      if (s_r.stat_go) begin
         if (s_r.tx_cnt != `HSP_TX_DEPTH) begin
            tx_we          = 1'b1;
            tx_wd          = stat_byte(s_r.stat_idx);
            s_nxt.stat_idx = s_r.stat_idx + 3'h1;
            if (s_r.stat_idx == `HSP_STAT_LEN - 3'h1) begin
               s_nxt.stat_go = 1'b0;
            end
         end
      end else if (sys_tx.valid) begin
         if (sys_tx_first) begin
            s_nxt.tx_drop_pkt = (`HSP_TX_DEPTH - s_r.tx_cnt) < sys_tx_len;
            s_nxt.tx_drop     = s_nxt.tx_drop_pkt;
         end
         if (!s_nxt.tx_drop_pkt) begin
            tx_we = 1'b1;
            tx_wd = sys_tx.data;
         end
      end
      if (tx_we) begin
         s_nxt.tx_wr  = wrap(s_r.tx_wr, `HSP_TX_DEPTH);
         s_nxt.tx_cnt = s_nxt.tx_cnt + 12'h001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_r     <= '0;
         s_r.sel <= HSP_BOOT;
         s_r.ft  <= `HSP_FT_DEFAULT;
         s_r.dout_s <= 2'b11;
         s_r.ssel_s <= 2'b11;
         s_r.rts_s  <= 2'b11;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Buffer storage, written only through the accepted paths
   always_ff @(posedge ref_clk) begin
      if (rx_we) begin
         rx_mem[s_r.rx_wr] <= rx_wd;
      end
      if (tx_we) begin
         tx_mem[tx_wr_idx] <= tx_wd;
      end
   end

   // Word crossing: byte is held steady until the toggle is echoed
   assign tx_req_r  = s_r.req;
   assign tx_byte_r = s_r.tbyte;

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign active_cfg    = s_r.forced ? s_r.fcfg : stored_cfg;
   assign flash_store   = s_r.flash_store;
   assign ft_value      = s_r.ft;
   assign cts_n_out     = cts_function_setting && s_r.sel != HSP_SPI
                          && s_r.stop;
   assign uart_tx       = s_r.utx;
   assign rx_out.valid  = s_r.rx_cnt != 12'h000;
   assign rx_out.data   = rx_mem[s_r.rx_rd];
   assign rx_drop       = s_r.rx_drop;
   assign sys_tx_ready  = ~s_r.stat_go;
   assign tx_drop       = s_r.tx_drop;
   assign port_sel      = s_r.sel;
   // Held while a byte is in flight so the host keeps clocking
   assign attention_out = s_r.sel == HSP_SPI &&
                          (s_r.tx_cnt != 12'h000 || s_r.req != s_r.ack_s[1]);

endmodule : hsp_serial_port

// File: hdl/hsp_regs.svh
// Constants of the host serial port select and flow control block
//------------------------------------------------------------------
// Summary of operation
// - Through-hole part with serial output pin low at reset forces SPI.
// - After forced SPI setup a modem status frame is queued, raising attention.
// - Forcing SPI rewrites pin1..4 and dio12 settings; pin1 only if zero.
// - Forced settings revert at reset unless flash write issued in SPI.
// - Stored config UART off, SPI on starts in SPI without forcing.
// - Both ports enabled: output to UART until first input picks port.
// - Selected port stays until device reset, whatever config arrives.
// - Surface-mount part ignores low output pin; low select picks SPI.
// - MISO driven only while select low; released when select rises.
// - With nothing queued the SPI output repeats its last bit.
// - SPI output carries unescaped API frames only.
// - Receive buffer overflow discards new data, keeps buffered data.
// - Transmit buffer lacking room for a whole packet drops it whole.
// - No flow control on SPI; UART CTS and RTS enabled separately.
// - Receive buffer 2100 bytes; threshold capped at 2083 bytes.
// - Threshold defaults to 2035 bytes, leaving 65 bytes of slack.
// - CTS released only when occupancy is threshold minus 17 or less.
// - RTS flow control holds UART output while host RTS is high.
// - Up to four characters may follow an RTS deassertion.
// - SPI uses clock idle low, data sampled on leading edge.
// - SPI bytes shift most significant bit first.
// - Attention asserted in SPI mode while output data queued; drops once the last byte is loaded for shifting.
//------------------------------------------------------------------
`ifndef HSP_REGS_SVH
`define HSP_REGS_SVH
`define HSP_RX_DEPTH     12'h834
`define HSP_TX_DEPTH     12'h100
`define HSP_FT_MAX       12'h823
`define HSP_FT_DEFAULT   12'h7f3
`define HSP_FT_HYST      12'h011
`define HSP_STRAP_CYC    8'h40
`define HSP_FN_SPI       4'h1
`define HSP_FN_ZERO      4'h0
`define HSP_FN_ON        4'h1
`define HSP_STAT_LEN     3'h6
`define HSP_LAST_BIT     3'h7
`endif

// File: hdl/hsp_pkg.sv
// Types of the host serial port select and flow control block
package hsp_pkg;
   typedef enum logic [3:0] {
      HSP_BOOT  = 4'b0001,
      HSP_UNDEC = 4'b0010,
      HSP_UART  = 4'b0100,
      HSP_SPI   = 4'b1000
   } hsp_sel_e;

   typedef struct packed {
      logic [3:0] pin1;
      logic [3:0] pin2;
      logic [3:0] pin3;
      logic [3:0] pin4;
      logic [3:0] dio12;
   } hsp_cfg_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } hsp_byte_s;
endpackage : hsp_pkg

// File: bench/hsp_serial_port_sva.sv
// Assertion checker for the host serial port block
`timescale 1ns/1ps
module hsp_serial_port_sva
   import hsp_pkg::*;
(
   input wire logic        ref_clk,                // Module clock
   input wire logic        rst,                    // Sync reset, high
   input wire logic        cts_function_setting,   // CTS enable
   input wire logic        rts_function_setting,   // RTS enable
   input wire logic [11:0] flow_threshold_setting, // Threshold request
   input wire logic        ft_wr,                  // Threshold load
   input wire logic [11:0] ft_value,               // Threshold in force
   input wire logic        rts_n_in,               // Host RTS
   input wire logic        cts_n_out,              // CTS, high = stop
   input wire hsp_byte_s   uart_tx,                // Byte to UART
   input wire logic        uart_tx_ready,          // UART accepts
   input wire hsp_byte_s   rx_out,                 // Receive head
   input wire logic        rx_drop,                // Receive discard
   input wire logic        flash_wr_cmd,           // Flash write command
   input wire logic        flash_store,            // Flash store pulse
   input wire logic [3:0]  port_sel,               // Selection state
   input wire logic        spi_ssel_n,             // SPI select
   input wire logic        spi_miso_oe,            // MISO enable
   input wire logic        attention_out           // Data queued
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   //------------------------------------------------------------------
   // Properties
   //------------------------------------------------------------------
   ft_clamp_a: assert property (ft_wr |=>
      ft_value == ($past(flow_threshold_setting) > 12'h823 ? 12'h823
                   : $past(flow_threshold_setting))) else $error("threshold not clamped");
   rst_dflt_a: assert property (disable iff (1'b0) rst |=>
      ft_value == 12'h7f3 && port_sel == 4'h1 && !attention_out && !cts_n_out)
      else $error("reset state wrong");
   miso_oe_a: assert property (spi_miso_oe == !spi_ssel_n)
      else $error("miso enable not tied to select");
   cts_off_a: assert property ((port_sel == 4'h8 || !cts_function_setting) |-> !cts_n_out)
      else $error("stop raised without flow control");
   sel_hold_a: assert property ((port_sel[3] || port_sel[2]) |=> $stable(port_sel))
      else $error("selection changed");
   rts_hold_a: assert property ((rts_function_setting && rts_n_in) [*6] |=>
      !$rose(uart_tx.valid)) else $error("byte sent while host stopped");
   tx_keep_a: assert property (uart_tx.valid && !uart_tx_ready |=>
      uart_tx.valid && $stable(uart_tx.data)) else $error("uart byte not held");
   drop_keep_a: assert property (rx_drop |-> rx_out.valid)
      else $error("drop with empty buffer");
   attn_spi_a: assert property (attention_out |-> port_sel == 4'h8)
      else $error("attention outside spi");
   flash_spi_a: assert property (flash_store |-> $past(flash_wr_cmd) && port_sel == 4'h8)
      else $error("flash store without command");
   cover property (port_sel == 4'h8 && attention_out);
   cover property (port_sel == 4'h4 && cts_n_out);
   cover property (rx_drop);
endmodule : hsp_serial_port_sva

// File: bench/hsp_spi_master.sv
// SPI master model standing in for the host microcontroller
`timescale 1ns/1ps
module hsp_spi_master (
   output logic      spi_sck,    // Clock, still outside frames
   output logic      spi_ssel_n, // Select, low
   output logic      spi_mosi,   // Data to device
   input  wire logic spi_miso    // Data from device
);
   initial begin
      spi_sck    = 1'b0;
      spi_ssel_n = 1'b1;
      spi_mosi   = 1'b0;
   end
   task automatic start();
      #1.3 spi_ssel_n = 1'b0;
      #15;
   endtask : start
   // Data is set while the clock is low and sampled just before it rises
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_mosi = tx[i];
         #14 rx[i] = spi_miso;
         #1 spi_sck = 1'b1;
         #15 spi_sck = 1'b0;
      end
   endtask : xfer
   // Released data line shows the inverse, never a stale copy
   task automatic stop();
      #15 spi_ssel_n = 1'b1;
      spi_mosi = ~spi_mosi;
   endtask : stop
endmodule : hsp_spi_master

// File: bench/testbench.sv
// Self-checking testbench of the host serial port block
`timescale 1ns/1ps
module testbench;
   import hsp_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        th, dout, uen, sen, fw, cts_en, rts_en, ftw, rts_n, utr, rxr, first;
   logic        fstore, cts_n, rxd, str, txd, attn, miso_o, miso_oe, frc;
   logic [11:0] ft_set, len, ftv;
   logic [3:0]  psel;
   logic [7:0]  rb;
   logic [15:0] rows [5];
   logic [63:0] frame = 64'h007e00028a0075ff;
   hsp_cfg_s    scfg, acfg;
   hsp_byte_s   urx, stx, utx, rxo;
   wire         sck, ssel_n, mosi;
   wire         miso_w = miso_oe ? miso_o : 1'bz;
   int          err_total, samples_checked, sent, drops, rdrops, k;

   always #4 ref_clk = ~ref_clk;

   hsp_serial_port i_hsp_serial_port (
      .ref_clk(ref_clk), .rst(rst), .th_variant(th), .dout_pin_in(dout),
      .uart_en_cfg(uen), .spi_en_cfg(sen), .stored_cfg(scfg), .flash_wr_cmd(fw),
      .active_cfg(acfg), .flash_store(fstore), .cts_function_setting(cts_en),
      .rts_function_setting(rts_en), .flow_threshold_setting(ft_set), .ft_wr(ftw),
      .ft_value(ftv), .rts_n_in(rts_n), .cts_n_out(cts_n), .uart_rx(urx), .uart_tx(utx),
      .uart_tx_ready(utr), .rx_out(rxo), .rx_out_ready(rxr), .rx_drop(rxd), .sys_tx(stx),
      .sys_tx_first(first), .sys_tx_len(len), .sys_tx_ready(str), .tx_drop(txd),
      .port_sel(psel), .spi_sck(sck), .spi_ssel_n(ssel_n), .spi_mosi(mosi),
      .spi_miso_o(miso_o), .spi_miso_oe(miso_oe), .attention_out(attn));
   hsp_spi_master i_hsp_spi_master (
      .spi_sck(sck), .spi_ssel_n(ssel_n), .spi_mosi(mosi), .spi_miso(miso_w));

   task automatic results();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_up(input logic ok);
      if (!ok) begin
         err_total++;
         $display("unexpected at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
         results();
      end
   endtask : give_up
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic boot(input logic [3:0] straps, input logic [3:0] p1);
      rst = 1'b1;
      {th, dout, uen, sen} = straps;
      scfg = {p1, 16'h5555};
      cyc(8);
      rst = 1'b0;
      cyc(80); // Boot window closes after 65 cycles
      sent = 0;
      drops = 0;
      rdrops = 0;
   endtask : boot
   task automatic pop(input int n);
      rxr = 1'b1;
      cyc(n);
      rxr = 1'b0;
   endtask : pop
   task automatic pkt(input int n, input logic [7:0] base);
      len = n[11:0];
      for (int i = 0; i < n; i++) begin
         stx = {1'b1, base + i[7:0]};
         first = (i == 0);
         cyc(1);
      end
      stx.valid = 1'b0;
      first = 1'b0;
   endtask : pkt

   // Looks between edges, after stimulus has settled
   always @(negedge ref_clk) begin
      #2;
      if (txd) drops++;
      if (rxd) rdrops++;
      if (utx.valid && utr) begin
         chk(utx.data, sent[7:0]);
         sent++;
      end
   end

   initial begin
      {th, dout, uen, sen, fw, cts_en, rts_en, ftw, rts_n, utr, rxr, first} = '0;
      {ft_set, len, scfg, urx, stx} = '0;
      // Rows: straps th,dout,uart,spi | stored pin1 | port_sel | pin1 in force
      rows = '{16'hb081, 16'hb383, 16'h3020, 16'h5282, 16'hf222};
      foreach (rows[r]) begin
         boot(rows[r][15:12], rows[r][11:8]);
         frc = rows[r][15] & ~rows[r][14];
         chk(psel, rows[r][7:4]);
         chk({acfg.pin1, acfg.pin2, acfg.dio12}, {rows[r][3:0], frc ? 8'h11 : 8'h55});
         chk(attn, frc);
         chk(ftv, 12'h7f3);
         chk(str, 1'b1);
      end
      //------------------------------------------------------------------
      // Forced SPI: status frame, idle fill, release and attention
      //------------------------------------------------------------------
      boot(4'hb, 4'h0);
      i_hsp_spi_master.start();
      for (int b = 7; b >= 0; b--) begin
         i_hsp_spi_master.xfer(b == 7 ? 8'hc3 : 8'h00, rb);
         chk(rb, frame[8*b +: 8]);
      end
      i_hsp_spi_master.stop();
      cyc(1);
      chk(miso_oe, 1'b0);
      for (k = 0; k < 20 && attn; k++) cyc(1);
      give_up(!attn);
      chk(rxo, {1'b1, 8'hc3});
      fw = 1'b1;
      cyc(1);
      fw = 1'b0;
      chk(fstore, 1'b1);
      // Surface-mount part picks SPI from the select line
      boot(4'h3, 4'h0);
      i_hsp_spi_master.start();
      i_hsp_spi_master.xfer(8'h35, rb);
      i_hsp_spi_master.stop();
      cyc(6);
      chk(psel, 4'h8);
      chk(rxo, {1'b1, 8'h35});
      //------------------------------------------------------------------
      // UART: selection, RTS hold, whole-packet drop
      //------------------------------------------------------------------
      boot(4'h3, 4'h0);
      urx = {1'b1, 8'h3c};
      cyc(1);
      urx.valid = 1'b0;
      cyc(1);
      chk({psel, rxo}, {4'h4, 1'b1, 8'h3c});
      pop(1);
      i_hsp_spi_master.start();
      i_hsp_spi_master.xfer(8'h11, rb);
      i_hsp_spi_master.stop();
      cyc(6);
      chk({psel, rxo.valid}, {4'h4, 1'b0});
      {rts_en, rts_n, cts_en} = 3'b111;
      cyc(4);
      pkt(201, 8'h00);
      cyc(1);
      pkt(100, 8'h80);
      cyc(20);
      chk(drops, 1);
      chk(sent, 0);
      rts_n = 1'b0;
      utr = 1'b1;
      for (k = 0; k < 600 && sent < 201; k++) cyc(1);
      give_up(sent == 201);
      cyc(20);
      chk(sent, 201);
      utr = 1'b0;
      // Stop threshold and its hysteresis
      ft_set = 12'h020;
      ftw = 1'b1;
      cyc(1);
      ftw = 1'b0;
      for (int i = 0; i < 32; i++) begin
         urx = {1'b1, i[7:0]};
         cyc(1);
         if (i == 30) chk(cts_n, 1'b0);
      end
      urx.valid = 1'b0;
      cyc(2);
      chk(cts_n, 1'b1);
      pop(16);
      cyc(2);
      chk(cts_n, 1'b1);
      pop(1);
      cyc(2);
      chk(cts_n, 1'b0);
      pop(15);
      // Overflow keeps the old data and loses the newest byte
      for (int i = 0; i < 2101; i++) begin
         urx = {1'b1, i == 2100 ? 8'haa : i[7:0]};
         cyc(1);
      end
      urx.valid = 1'b0;
      cyc(2);
      chk(rdrops, 1);
      rxr = 1'b1;
      for (int i = 0; i < 2100; i++) begin
         chk(rxo, {1'b1, i[7:0]});
         cyc(1);
      end
      rxr = 1'b0;
      chk(rxo.valid, 1'b0);
      ft_set = 12'h824;
      ftw = 1'b1;
      cyc(1);
      ftw = 1'b0;
      chk(ftv, 12'h823);
      results();
   end
endmodule : testbench

bind hsp_serial_port hsp_serial_port_sva i_hsp_serial_port_sva (
   .ref_clk(ref_clk), .rst(rst), .cts_function_setting(cts_function_setting),
   .rts_function_setting(rts_function_setting), .ft_wr(ft_wr), .ft_value(ft_value),
   .flow_threshold_setting(flow_threshold_setting), .rts_n_in(rts_n_in),
   .cts_n_out(cts_n_out), .uart_tx(uart_tx), .uart_tx_ready(uart_tx_ready),
   .rx_out(rx_out), .rx_drop(rx_drop), .flash_wr_cmd(flash_wr_cmd),
   .flash_store(flash_store), .port_sel(port_sel), .spi_ssel_n(spi_ssel_n),
   .spi_miso_oe(spi_miso_oe), .attention_out(attention_out));
